// ===== snc_pkg.sv
package snc_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] SNC_OP_RESET      = 8'hFF;
  localparam logic [7:0] SNC_OP_WREN       = 8'h06;
  localparam logic [7:0] SNC_OP_WRDI       = 8'h04;
  localparam logic [7:0] SNC_OP_GET_FEAT   = 8'h0F;
  localparam logic [7:0] SNC_OP_SET_FEAT   = 8'h1F;
  localparam logic [7:0] SNC_OP_ID_READ    = 8'h9F;
  localparam logic [7:0] SNC_OP_PAGE_READ  = 8'h13;
  localparam logic [7:0] SNC_OP_RAND_READ  = 8'h30;
  localparam logic [7:0] SNC_OP_PROG_EXEC  = 8'h10;
  localparam logic [7:0] SNC_OP_ERASE      = 8'hD8;
  localparam logic [7:0] SNC_OP_PERM_LOCK  = 8'h2C;
  localparam logic [7:0] SNC_OP_RC_X1A     = 8'h03;
  localparam logic [7:0] SNC_OP_RC_X1B     = 8'h0B;
  localparam logic [7:0] SNC_OP_RC_X2      = 8'h3B;
  localparam logic [7:0] SNC_OP_RC_X4      = 8'h6B;
  localparam logic [7:0] SNC_OP_PL_X1      = 8'h02;
  localparam logic [7:0] SNC_OP_PL_X4      = 8'h32;
  localparam logic [7:0] SNC_OP_PLR_X1     = 8'h84;
  localparam logic [7:0] SNC_OP_PLR_X4     = 8'h34;
  // ---------------------------------------------------------------
  // Feature addresses and values
  // ---------------------------------------------------------------
  localparam logic [7:0] SNC_FA_CFG        = 8'hB0;
  localparam logic [7:0] SNC_FA_STATUS     = 8'hC0;
  localparam logic [7:0] SNC_FA_LOCK       = 8'hA0;
  localparam logic [7:0] SNC_CFG_OTP_MODE  = 8'h40;
  localparam logic [7:0] SNC_CFG_ECC_ON    = 8'h10;
  localparam logic [7:0] SNC_CFG_ECC_OFF   = 8'h00;
  localparam logic [7:0] SNC_CFG_OTP_MASK  = 8'hE0;
  localparam logic [7:0] SNC_CFG_RESET     = 8'h10;
  localparam logic [7:0] SNC_LOCK_RESET    = 8'h38;
  localparam int         SNC_ST_OIP_BIT    = 0;
  localparam int         SNC_ST_WEL_BIT    = 1;
  localparam int         SNC_ST_EFAIL_BIT  = 2;
  localparam int         SNC_ST_PFAIL_BIT  = 3;
  // ---------------------------------------------------------------
  // Address formats
  // ---------------------------------------------------------------
  localparam int         SNC_ADDR24_BYTES  = 3;
  localparam int         SNC_ADDR16_BYTES  = 2;
  localparam int         SNC_ROW_DUMMY_1G  = 8;
  localparam int         SNC_ROW_DUMMY_2G  = 7;
  localparam int         SNC_COL_DUMMY     = 4;
  localparam int         SNC_COL_BITS      = 12;
  localparam int         SNC_ROW_BITS_2G   = 17;
  // ---------------------------------------------------------------
  // Parameter page content
  // ---------------------------------------------------------------
  localparam int         SNC_PTAB_BYTES    = 256;
  localparam logic [15:0] SNC_CRC_POLY     = 16'h8005;
  localparam logic [15:0] SNC_CRC_INIT     = 16'h4F4E;
  localparam logic [15:0] SNC_T_PROG_US    = 16'h0320;
  localparam logic [15:0] SNC_T_BERS_US    = 16'h2710;
  localparam logic [15:0] SNC_T_READ_US    = 16'h0019;
  localparam logic [7:0] SNC_PROG_PER_PAGE = 8'h04;
  localparam logic [7:0] SNC_ECC_BITS      = 8'h08;
  localparam int         SNC_UID_COPIES    = 16;
  localparam int         SNC_UID_COPY_LEN  = 32;
  localparam int         SNC_UID_HALF      = 16;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         SNC_CLK_NS        = 100;
  localparam int         SNC_POR_US        = 2000;
  localparam int         SNC_RST_US        = 5;
  localparam int         SNC_POR_CYC       = SNC_POR_US * 1000 / SNC_CLK_NS;
  localparam int         SNC_RST_CYC       = SNC_RST_US * 1000 / SNC_CLK_NS;
  localparam int         SNC_READ_CYC      = 25 * 1000 / SNC_CLK_NS;
  localparam int         SNC_CNT_W         = 24;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] SNC_REG_CTRL      = 8'h00;
  localparam logic [7:0] SNC_REG_STATUS    = 8'h04;
  localparam logic [7:0] SNC_REG_CFG       = 8'h08;
  localparam logic [7:0] SNC_REG_ROW       = 8'h0C;
  localparam logic [7:0] SNC_REG_COL       = 8'h10;
  localparam logic [7:0] SNC_REG_CRC       = 8'h14;
  localparam int         SNC_CTRL_DEN_BIT  = 0;
  localparam int         SNC_CTRL_CRC_BIT  = 1;
  localparam logic [31:0] SNC_MFR_ID       = 32'h0000005A;  // Arbitrary value.
endpackage

// ===== snc_crc16.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// One byte step of the integrity checksum, MSB first.
// ---------------------------------------------------------------
module snc_crc16
  import snc_pkg::*;
#(
  parameter logic [15:0] POLY = SNC_CRC_POLY
)
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  // Eight shift steps unrolled by the loop; the polynomial feeds back on a carry.
  always_comb
  begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ data_in[i])
        c = {c[14:0], 1'b0} ^ POLY;
      else
        c = {c[14:0], 1'b0};
    end
    crc_out = c;
  end
endmodule

// ===== snc_core.sv
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// How it works
// - Parameter page checksum uses x16+x15+x2+1
// - Parameter table repeats every 256 bytes
// - Page reports program, erase, read maxima
// - Page reports four programs, eight ECC bits
// - Identifier: sixteen copies, data then complement
// - Power-up loads first page automatically
// - FFh aborts any busy operation
// - Reset clears status, OTP config bits
// - Reset leaves block lock bits alone
// - During reset busy, feature and ID reads work
// - 06h sets write enable latch
// - 04h clears write enable latch
// - Listed opcodes take 24-bit addresses
// - Listed opcodes take 16-bit addresses
// - Row address: dummy bits then row bits
// - Column address: 4 dummy, 12 column bits
module snc_core
  import snc_pkg::*;
#(
  parameter int POR_CYC  = SNC_POR_CYC,
  parameter bit DEN_2G   = 1'b0
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe
);
  initial
  begin
    if (POR_CYC < 1)
      $error("POR_CYC must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sck_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] si_sync_reg;
  logic       sck_prev_reg;
  // Two stages per pin; only the second stage is read beyond here.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_sync_reg <= 2'h0;
      cs_sync_reg  <= 2'h3;
      si_sync_reg  <= 2'h0;
      sck_prev_reg <= 1'b0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[0], sck};
      cs_sync_reg  <= {cs_sync_reg[0], cs_n};
      si_sync_reg  <= {si_sync_reg[0], si};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  wire sck_s    = sck_sync_reg[1];
  wire cs_act   = ~cs_sync_reg[1];
  wire sck_rise = sck_s & ~sck_prev_reg & cs_act;
  wire sck_fall = ~sck_s & sck_prev_reg & cs_act;

  // ---------------------------------------------------------------
  // Command phase machine
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SNC_PH_OP   = 5'b00001,
    SNC_PH_ADDR = 5'b00010,
    SNC_PH_DATA = 5'b00100,
    SNC_PH_OUT  = 5'b01000,
    SNC_PH_IGN  = 5'b10000
  } snc_phase_t;

  snc_phase_t  phase_reg;
  snc_phase_t  phase_next;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  op_reg;
  logic [1:0]  abyte_reg;
  logic [23:0] addr_reg;
  logic [7:0]  out_reg;
  logic [7:0]  fa_reg;
  logic        wel_reg;
  logic        busy_reg;
  logic        efail_reg;
  logic        pfail_reg;
  logic [7:0]  cfg_reg;
  logic [7:0]  lock_reg;
  logic [SNC_CNT_W-1:0] busy_cnt_reg;
  logic [16:0] row_reg;
  logic [11:0] col_reg;
  logic        cache_loaded_reg;
  logic        refused_reg;

  wire [7:0] byte_in   = {shift_reg[6:0], si_sync_reg[1]};
  wire       byte_done = sck_rise && (bit_cnt_reg == 3'h7);

  // Address length per opcode.
  wire is_a24 = (op_reg == SNC_OP_PAGE_READ) || (op_reg == SNC_OP_RAND_READ) ||
                (op_reg == SNC_OP_PROG_EXEC) || (op_reg == SNC_OP_ERASE) ||
                (op_reg == SNC_OP_PERM_LOCK);
  wire is_a16 = (op_reg == SNC_OP_RC_X1A) || (op_reg == SNC_OP_RC_X1B) ||
                (op_reg == SNC_OP_RC_X2) || (op_reg == SNC_OP_RC_X4) ||
                (op_reg == SNC_OP_PL_X1) || (op_reg == SNC_OP_PL_X4) ||
                (op_reg == SNC_OP_PLR_X1) || (op_reg == SNC_OP_PLR_X4);
  wire [1:0] a_len = is_a24 ? 2'(SNC_ADDR24_BYTES) : 2'(SNC_ADDR16_BYTES);

  // While busy only reset, feature read and ID read are served.
  wire op_ok_busy  = (byte_in == SNC_OP_RESET) || (byte_in == SNC_OP_GET_FEAT) ||
                     (byte_in == SNC_OP_ID_READ);
  wire alter_op    = (op_reg == SNC_OP_PROG_EXEC) || (op_reg == SNC_OP_ERASE);
  wire addr_last   = byte_done && (abyte_reg == a_len - 2'h1);

  // Identifier page: an x1 cache read (03h or 0Bh) in OTP mode after page 0 was fetched streams the copies.
  // Arbitrary value; every part would carry its own.
  localparam logic [127:0] UID_BITS = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  wire       uid_rd   = (op_reg == SNC_OP_RC_X1A || op_reg == SNC_OP_RC_X1B) &&
                        cfg_reg == SNC_CFG_OTP_MODE && row_reg == 17'h00000;
  wire [7:0] uid_data = UID_BITS[8 * addr_reg[3:0] +: 8];
  // Second half of each copy is the complement; past the last copy the page reads zero.
  wire [7:0] uid_byte = (addr_reg[11:0] < 12'(SNC_UID_COPIES * SNC_UID_COPY_LEN)) ?
                        uid_data ^ {8{addr_reg[4]}} : 8'h00;

  // Row and column fields extracted from the shifted address.
  wire [16:0] row_field = DEN_2G ? addr_reg[16:0] : {1'b0, addr_reg[15:0]};
  wire [11:0] col_field = addr_reg[11:0];

  // Feature opcodes go to DATA, ID read to output; FFh, 06h, 04h and refused opcodes wait in IGN for chip select to rise; any other goes to ADDR.
  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      SNC_PH_OP:
        if (byte_done)
        begin
          if (busy_reg && !op_ok_busy)
            phase_next = SNC_PH_IGN;
          else if (byte_in == SNC_OP_GET_FEAT || byte_in == SNC_OP_SET_FEAT)
            phase_next = SNC_PH_DATA;
          else if (byte_in == SNC_OP_ID_READ)
            phase_next = SNC_PH_OUT;
          else if (byte_in == SNC_OP_RESET || byte_in == SNC_OP_WREN ||
                   byte_in == SNC_OP_WRDI)
            phase_next = SNC_PH_IGN;
          else
            phase_next = SNC_PH_ADDR;
        end
      SNC_PH_ADDR:
        if (addr_last)
          phase_next = uid_rd ? SNC_PH_DATA : SNC_PH_IGN;
      SNC_PH_DATA:
        if (byte_done)
          phase_next = (op_reg == SNC_OP_GET_FEAT || uid_rd) ? SNC_PH_OUT : SNC_PH_IGN;
      SNC_PH_OUT:
        phase_next = SNC_PH_OUT;
      SNC_PH_IGN:
        phase_next = SNC_PH_IGN;
      default:
        phase_next = SNC_PH_OP;
    endcase
    if (!cs_act)
      phase_next = SNC_PH_OP;
  end

  // Status byte as read at feature address C0h.
  wire [7:0] status_byte = {4'h0, pfail_reg, efail_reg, wel_reg, busy_reg};
  wire [7:0] feat_byte   = (byte_in == SNC_FA_STATUS) ? status_byte :
                           (byte_in == SNC_FA_CFG)    ? cfg_reg     :
                           (byte_in == SNC_FA_LOCK)   ? lock_reg    : 8'h00;

  // Serial shifting, opcode capture and read-out.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg   <= SNC_PH_OP;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 3'h0;
      op_reg      <= 8'h00;
      abyte_reg   <= 2'h0;
      addr_reg    <= 24'h000000;
      out_reg     <= 8'h00;
      fa_reg      <= 8'h00;
      so          <= 1'b0;
      so_oe       <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      if (!cs_act)
      begin
        bit_cnt_reg <= 3'h0;
        abyte_reg   <= 2'h0;
        so_oe       <= 1'b0;
      end
      else if (sck_rise)
      begin
        shift_reg   <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_done && phase_reg == SNC_PH_OP)
        begin
          // A refused opcode must not act when chip select rises.
          op_reg   <= (busy_reg && !op_ok_busy) ? 8'h00 : byte_in;
          addr_reg <= 24'h000000;
          if (byte_in == SNC_OP_ID_READ)
            out_reg <= SNC_MFR_ID[7:0];
        end
        if (byte_done && phase_reg == SNC_PH_ADDR)
        begin
          addr_reg  <= {addr_reg[15:0], byte_in};
          abyte_reg <= abyte_reg + 2'h1;
        end
        if (byte_done && phase_reg == SNC_PH_DATA)
        begin
          fa_reg <= byte_in;
          if (op_reg == SNC_OP_GET_FEAT)
            out_reg <= feat_byte;
          else if (uid_rd)
          begin
            out_reg  <= uid_byte;
            addr_reg <= addr_reg + 24'h000001;
          end
        end
        if (byte_done && phase_reg == SNC_PH_OUT && uid_rd)
        begin
          out_reg  <= uid_byte;
          addr_reg <= addr_reg + 24'h000001;
        end
      end
      else if (sck_fall && phase_reg == SNC_PH_OUT)
      begin
        so      <= out_reg[3'h7 - bit_cnt_reg];
        so_oe   <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Operation state: latch, busy timer, configuration
  // ---------------------------------------------------------------
  wire op_end   = cs_act == 1'b0 && cs_sync_reg[1] && phase_reg == SNC_PH_IGN;
  wire do_reset = op_end && op_reg == SNC_OP_RESET;
  wire do_wren  = op_end && op_reg == SNC_OP_WREN;
  wire do_wrdi  = op_end && op_reg == SNC_OP_WRDI;
  wire do_setf  = op_end && op_reg == SNC_OP_SET_FEAT;
  wire do_addr  = op_end && abyte_reg == a_len && (is_a24 || is_a16);
  wire do_alter = do_addr && alter_op;
  wire por_done = busy_cnt_reg == SNC_CNT_W'(0);
  // Leaving the opcode machine in IGN after an address marks a completed command.

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wel_reg          <= 1'b0;
      busy_reg         <= 1'b1;
      efail_reg        <= 1'b0;
      pfail_reg        <= 1'b0;
      cfg_reg          <= SNC_CFG_RESET;
      lock_reg         <= SNC_LOCK_RESET;
      busy_cnt_reg     <= SNC_CNT_W'(POR_CYC);
      row_reg          <= 17'h00000;
      col_reg          <= 12'h000;
      cache_loaded_reg <= 1'b0;
      refused_reg      <= 1'b0;
    end
    else
    begin
      if (busy_reg && !por_done)
        busy_cnt_reg <= busy_cnt_reg - SNC_CNT_W'(1);
      if (busy_reg && por_done)
      begin
        busy_reg         <= 1'b0;
        cache_loaded_reg <= 1'b1;
      end
      if (do_wren)
        wel_reg <= 1'b1;
      if (do_wrdi)
        wel_reg <= 1'b0;
      if (do_setf && fa_reg == SNC_FA_CFG)
        cfg_reg <= shift_reg;
      if (do_setf && fa_reg == SNC_FA_LOCK)
        lock_reg <= shift_reg;
      if (do_addr && is_a24)
        row_reg <= row_field;
      if (do_addr && is_a16)
        col_reg <= col_field;
      if (do_alter && !wel_reg)
        refused_reg <= 1'b1;
      else if (do_alter)
      begin
        busy_reg     <= 1'b1;
        busy_cnt_reg <= SNC_CNT_W'(SNC_READ_CYC);
        wel_reg      <= 1'b0;
      end
      else if (do_addr && op_reg == SNC_OP_PAGE_READ)
      begin
        busy_reg     <= 1'b1;
        busy_cnt_reg <= SNC_CNT_W'(SNC_READ_CYC);
      end
      // Reset aborts the busy operation and clears status and OTP mode.
      if (do_reset)
      begin
        busy_reg     <= 1'b1;
        busy_cnt_reg <= SNC_CNT_W'(SNC_RST_CYC);
        wel_reg      <= 1'b0;
        efail_reg    <= 1'b0;
        pfail_reg    <= 1'b0;
        refused_reg  <= 1'b0;
        cfg_reg      <= cfg_reg & ~SNC_CFG_OTP_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // Parameter page checksum over bytes 0 to 253 of a 256-byte table image
  // ---------------------------------------------------------------
  logic [15:0] crc_reg;
  logic [15:0] crc_step;
  logic [7:0]  crc_idx_reg;
  logic        crc_run_reg;
  logic [7:0]  ptab_byte;

  // Table image: timing maxima little-endian, program count, ECC bits.
  always_comb
  begin
    case (crc_idx_reg)
      8'd110:  ptab_byte = SNC_PROG_PER_PAGE;
      8'd133:  ptab_byte = SNC_T_PROG_US[7:0];
      8'd134:  ptab_byte = SNC_T_PROG_US[15:8];
      8'd135:  ptab_byte = SNC_T_BERS_US[7:0];
      8'd136:  ptab_byte = SNC_T_BERS_US[15:8];
      8'd137:  ptab_byte = SNC_T_READ_US[7:0];
      8'd138:  ptab_byte = SNC_T_READ_US[15:8];
      8'd248:  ptab_byte = SNC_ECC_BITS;
      default: ptab_byte = 8'h00;
    endcase
  end

  snc_crc16 #(.POLY(SNC_CRC_POLY)) u_crc (
    .crc_in  (crc_reg),
    .data_in (ptab_byte),
    .crc_out (crc_step)
  );

  // Bus-side decode.
  logic        dp_valid_reg;
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;
  wire         ap_take = hsel && hready && htrans[1];
  wire         wr_ctrl = dp_valid_reg && dp_write_reg && dp_addr_reg == SNC_REG_CTRL;
  // Copies of the table repeat every 256 bytes, so one pass covers all copies.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      crc_reg     <= SNC_CRC_INIT;
      crc_idx_reg <= 8'h00;
      crc_run_reg <= 1'b0;
    end
    else if (wr_ctrl && hwdata[SNC_CTRL_CRC_BIT])
    begin
      crc_reg     <= SNC_CRC_INIT;
      crc_idx_reg <= 8'h00;
      crc_run_reg <= 1'b1;
    end
    else if (crc_run_reg)
    begin
      crc_reg     <= crc_step;
      crc_idx_reg <= crc_idx_reg + 8'h01;
      crc_run_reg <= crc_idx_reg != 8'(SNC_PTAB_BYTES - 3);
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  wire [31:0] rd_mux =
    (dp_addr_reg == SNC_REG_STATUS) ? {27'h0, refused_reg, status_byte[3:0]} :
    (dp_addr_reg == SNC_REG_CFG)    ? {16'h0, lock_reg, cfg_reg} :
    (dp_addr_reg == SNC_REG_ROW)    ? {15'h0, row_reg} :
    (dp_addr_reg == SNC_REG_COL)    ? {20'h0, col_reg} :
    (dp_addr_reg == SNC_REG_CRC)    ? {15'h0, crc_run_reg, crc_reg} :
    (dp_addr_reg == SNC_REG_CTRL)   ? {31'h0, cache_loaded_reg} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      hrdata       <= 32'h0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
    else
    begin
      dp_valid_reg <= ap_take;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr[7:0];
      hrdata       <= (ap_take && !hwrite) ? rd_mux_next(haddr[7:0]) : hrdata;
    end
  end

  function automatic logic [31:0] rd_mux_next(input logic [7:0] a);
    rd_mux_next =
      (a == SNC_REG_STATUS) ? {27'h0, refused_reg, status_byte[3:0]} :
      (a == SNC_REG_CFG)    ? {16'h0, lock_reg, cfg_reg} :
      (a == SNC_REG_ROW)    ? {15'h0, row_reg} :
      (a == SNC_REG_COL)    ? {20'h0, col_reg} :
      (a == SNC_REG_CRC)    ? {15'h0, crc_run_reg, crc_reg} :
      (a == SNC_REG_CTRL)   ? {31'h0, cache_loaded_reg} : 32'h0;
  endfunction

  wire unused_ok = &{1'b0, hsize, rd_mux, DEN_2G};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence alter_seen;
    do_alter && !wel_reg;
  endsequence

  refuse_no_wel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    alter_seen |=> refused_reg && !(busy_reg && $rose(busy_reg)))
    else $error("program or erase started without latch");
  wren_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_wren && !do_reset |=> wel_reg)
    else $error("write enable did not set latch");
  wrdi_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_wrdi |=> !wel_reg)
    else $error("write disable did not clear latch");
  reset_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_reset |=> busy_reg && !wel_reg && !efail_reg)
    else $error("reset did not abort and clear status");
  reset_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_reset && !do_setf |=> $stable(lock_reg))
    else $error("reset changed lock bits");
  reset_otp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    do_reset |=> (cfg_reg & SNC_CFG_OTP_MASK) == 8'h00)
    else $error("reset left otp bits set");
  power_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(busy_reg) |-> cache_loaded_reg)
    else $error("cache not loaded after power-up");
  crc_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(crc_run_reg) |-> ##[254:256] !crc_run_reg)
    else $error("checksum pass length wrong");
endmodule

// ===== snc_spi_host.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host controller on the serial link, mode 0, 800 ns link clock.
// ---------------------------------------------------------------
module snc_spi_host
(
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  // The link clock stands low between frames.
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // The last 256 bits seen on the data-out line at a rising link clock edge, newest last.
  logic [255:0] rx;

  // One command frame, MSB first; data idles inverted so a stale bit never passes for a real one.
  task automatic frame(input logic [7:0] b [$]);
    #430 cs_n = 1'b0;
    foreach (b[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        si = b[i][k];
        #400 sck = 1'b1;
        rx = {rx[254:0], so};
        #400 sck = 1'b0;
      end
    end
    #400 cs_n = 1'b1;
    si = ~si;
    #1600;
  endtask
endmodule

// ===== tb_spi_nand_command_control.sv
`timescale 1ns/1ps
module tb_spi_nand_command_control
  import snc_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        hreadyout, hresp, sck, cs_n, si, so, so_oe;
  int          miscompares = 0, cmp_count = 0, seed = 32'hBA5CA6C5, row, col;
  logic [7:0]  q [$];

  always #50 hclk = ~hclk;

  snc_core #(.POR_CYC(50), .DEN_2G(1'b0)) i_snc_core (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  // A released data line shows the inverse, so an undriven bit never reads right.
  snc_spi_host i_snc_spi_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_oe ? so : ~so));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Checksum of the table image: times little-endian, program count, ECC bits.
  function automatic logic [15:0] crc_model();
    logic [15:0] c;
    logic [7:0]  d;
    c = SNC_CRC_INIT;
    for (int i = 0; i < 254; i++)
    begin
      d = (i == 110) ? 8'h04 : (i == 248) ? 8'h08 : (i == 133) ? 8'h20 : (i == 134) ? 8'h03 :
          (i == 135) ? 8'h10 : (i == 136) ? 8'h27 : (i == 137) ? 8'h19 : 8'h00;
      for (int k = 7; k >= 0; k--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction

  // One single AHB transfer; the wait for hready is bounded.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    for (int p = 0; p < 2; p++)
    begin
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 50)
      begin
        @(posedge hclk);
        n++;
      end
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
    end
    v = hrdata;
    if (n >= 50)
    begin
      miscompares++;
      print_verdict();
    end
  endtask

  // Polls a register bit, by default the busy flag, with a bound.
  task automatic wait_idle(input logic [7:0] a = SNC_REG_STATUS, input int b = SNC_ST_OIP_BIT);
    int n;
    n = 0;
    ahb(1'b0, a, 32'h0);
    while (v[b] !== 1'b0 && n < 400)
    begin
      ahb(1'b0, a, 32'h0);
      n++;
    end
    if (n >= 400)
    begin
      miscompares++;
      print_verdict();
    end
  endtask

  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    wait_idle();
    ahb(1'b0, SNC_REG_CTRL, 32'h0);
    chk(32'h1, v & 32'h1);
    i_snc_spi_host.frame('{SNC_OP_WREN});
    ahb(1'b0, SNC_REG_STATUS, 32'h0);
    chk(32'h2, v & 32'h12);
    i_snc_spi_host.frame('{SNC_OP_WRDI});
    i_snc_spi_host.frame('{SNC_OP_ERASE, 8'h00, 8'h01, 8'h40});
    ahb(1'b0, SNC_REG_STATUS, 32'h0);
    chk(32'h10, v & 32'h13);
    $display("latch test done");
    row = $random(seed) & 32'hFFFF;
    i_snc_spi_host.frame('{SNC_OP_PAGE_READ, 8'h00, row[15:8], row[7:0]});
    i_snc_spi_host.frame('{SNC_OP_GET_FEAT, SNC_FA_STATUS, 8'h00});
    chk(32'h1, {24'h0, i_snc_spi_host.rx[7:0]});
    chk(32'h0, {31'h0, so_oe});
    wait_idle();
    ahb(1'b0, SNC_REG_ROW, 32'h0);
    chk(row, v & 32'hFFFF);
    col = $random(seed) & 32'hFFF;
    i_snc_spi_host.frame('{SNC_OP_RC_X1A, {4'h0, col[11:8]}, col[7:0], 8'h00});
    ahb(1'b0, SNC_REG_COL, 32'h0);
    chk(col, v & 32'hFFF);
    $display("address test done");
    i_snc_spi_host.frame('{SNC_OP_SET_FEAT, SNC_FA_CFG, SNC_CFG_OTP_MODE});
    i_snc_spi_host.frame('{SNC_OP_PAGE_READ, 8'h00, 8'h00, 8'h00});
    wait_idle();
    q = '{SNC_OP_RC_X1A, 8'h00, 8'h00, 8'h00};
    repeat (32) q.push_back(8'h00);
    i_snc_spi_host.frame(q);
    chk(32'h1, {31'h0, &(i_snc_spi_host.rx[255:128] ^ i_snc_spi_host.rx[127:0])});
    i_snc_spi_host.frame('{SNC_OP_SET_FEAT, SNC_FA_LOCK, 8'h00});
    i_snc_spi_host.frame('{SNC_OP_WREN});
    i_snc_spi_host.frame('{SNC_OP_RESET});
    ahb(1'b0, SNC_REG_STATUS, 32'h0);
    chk(32'h1, v & 32'h1F);
    wait_idle();
    ahb(1'b0, SNC_REG_CFG, 32'h0);
    chk(32'h0, v & 32'hFFE0);
    i_snc_spi_host.frame('{SNC_OP_ID_READ, 8'h00});
    chk({24'h0, SNC_MFR_ID[7:0]}, {24'h0, i_snc_spi_host.rx[7:0]});
    i_snc_spi_host.frame('{SNC_OP_SET_FEAT, SNC_FA_CFG, SNC_CFG_ECC_ON});
    ahb(1'b0, SNC_REG_CFG, 32'h0);
    chk(32'h10, v & 32'hFF);
    ahb(1'b1, 8'h40, $random(seed));
    ahb(1'b0, 8'h40, 32'h0);
    chk(32'h0, v);
    $display("reset test done");
    ahb(1'b1, SNC_REG_CTRL, 32'h2);
    wait_idle(SNC_REG_CRC, 16);
    chk({16'h0, crc_model()}, v);
    chk(32'h0, {31'h0, hresp});
    $display("checksum test done");
    print_verdict();
  end
endmodule
